// File: err_flags_pkg.sv
// Constants and carrier types for the link-layer error flag bank
package err_flags_pkg;

    // Register bus geometry and byte offsets
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_FLAGS = 12'h000;
    localparam logic [11:0] OFF_CLEAR = 12'h004;
    localparam logic [11:0] OFF_ENABLE = 12'h008;

    // Flag field positions inside the flag register
    localparam int FLAG_W = 9;
    localparam int BIT_TX_ENC = 0;
    localparam int BIT_RX_DEC = 1;
    localparam int BIT_PKT_MEM = 2;
    localparam int BIT_RADIO_MEM = 3;
    localparam int BIT_SCHED_MEM = 4;
    localparam int BIT_ENTRY = 5;
    localparam int BIT_SCHED_PF = 6;
    localparam int BIT_CTRL_PF = 7;
    localparam int BIT_WHITELIST = 8;

    // Reset values
    localparam logic [8:0] FLAGS_RESET = 9'h000;
    localparam logic [8:0] ENABLE_RESET = 9'h000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Memory requestor order; requestor i drives flag BIT_PKT_MEM + i
    localparam int MEM_PKT = 0;
    localparam int MEM_RADIO = 1;
    localparam int MEM_SCHED = 2;
    localparam int MEM_PORTS = 3;

    // Longest wait for a memory grant, rounded down to whole cycles
    localparam int CLK_PERIOD_NS = 5;
    localparam int MEM_WAIT_MAX_NS = 40;
    localparam int MEM_WAIT_CYC = (MEM_WAIT_MAX_NS / CLK_PERIOD_NS) < 1 ?
        1 : (MEM_WAIT_MAX_NS / CLK_PERIOD_NS);
    localparam int WAIT_CNT_W = 4;
    localparam logic [3:0] MEM_WAIT_LAST = 4'(MEM_WAIT_CYC - 1);

    typedef logic [8:0] flag_vec_t;

    // Request and grant of one exchange-memory requestor
    typedef struct packed {
        logic req;
        logic gnt;
    } mem_port_t;

endpackage

// File: mem_deadline_watch.sv
`timescale 1ns/1ps
// Watchdog that flags a memory request left ungranted too long
module mem_deadline_watch (
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire err_flags_pkg::mem_port_t port, // Request and grant
    output logic late // One-cycle pulse on missed deadline
);

    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic fired_reg;
    logic fired_next;
    logic late_reg;
    logic late_next;

    // Count waiting cycles; one pulse per request, rearmed by grant or by the request dropping
    always_comb begin
        cnt_next = cnt_reg;
        fired_next = fired_reg;
        late_next = 1'b0;
        if (!port.req || port.gnt) begin
            cnt_next = 4'h0;
            fired_next = 1'b0;
        end else if (!fired_reg) begin
            if (cnt_reg == err_flags_pkg::MEM_WAIT_LAST) begin
                late_next = 1'b1;
                fired_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 4'h1;
            end
        end
    end

    // Register the watchdog state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 4'h0;
            fired_reg <= 1'b0;
            late_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            fired_reg <= fired_next;
            late_reg <= late_next;
        end
    end

    assign late = late_reg;

endmodule

// File: link_err_flags.sv
`timescale 1ns/1ps
// Link-layer error flag bank with AXI4-Lite access and interrupt
// Functional notes
// RULE_01: Whitelist flag (bit 8) sets when the search is still busy as its result is needed.
// RULE_02: A prefetch instant while the first event still runs sets bits 7 and 6.
// RULE_03: Two consecutive scheduling table entries with mismatched offset use set bit 5.
// RULE_04: A scheduler memory request not granted in time sets bit 4.
// RULE_05: A radio controller memory request not served in time sets bit 3.
// RULE_06: A packet controller memory request missing its deadline sets bit 2.
// RULE_07: A received block arriving before the previous one is decrypted sets bit 1.
// RULE_08: A send request meeting no encrypted block ready sets bit 0.
// RULE_09: Flags are read-only, read 1 after their error, and reset to 0.
// RULE_10: A set flag stays set until software clears it through the clear register.
module link_err_flags (
    input wire logic aclk, // System clock, 200 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [11:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic wl_search_busy, // Whitelist search running
    input wire logic wl_result_needed, // Pulse: search result due
    input wire logic evt_active, // First event not yet ended
    input wire logic evt_next_programmed, // Second event queued
    input wire logic prefetch_instant, // Pulse: prefetch instant
    input wire logic et_entry_valid, // Pulse: table entry read
    input wire logic et_entry_has_offset, // Entry carries an offset
    input wire err_flags_pkg::mem_port_t [2:0] mem_port, // Mem req/gnt
    input wire logic rx_block_in, // Pulse: packet ctrl gets block
    input wire logic rx_decrypt_done, // Pulse: block decrypted
    input wire logic tx_send_req, // Pulse: packet ctrl sends block
    input wire logic tx_block_ready, // Encrypted block is ready
    output logic [8:0] err_flags, // Current flags
    output logic irq // Level interrupt
);

    // Bus state
    logic aw_full_reg;
    logic aw_full_next;
    logic [11:0] awaddr_reg;
    logic [11:0] awaddr_next;
    logic w_full_reg;
    logic w_full_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0] wstrb_reg;
    logic [3:0] wstrb_next;
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic wr_fire;
    logic [8:0] wmask;
    err_flags_pkg::flag_vec_t clr_vec;

    // Flag, enable and detector state
    err_flags_pkg::flag_vec_t flags_reg;
    err_flags_pkg::flag_vec_t flags_next;
    err_flags_pkg::flag_vec_t en_reg;
    err_flags_pkg::flag_vec_t en_next;
    err_flags_pkg::flag_vec_t set_vec;
    logic irq_reg;
    logic irq_next;
    logic prev_valid_reg;
    logic prev_valid_next;
    logic prev_off_reg;
    logic prev_off_next;
    logic rx_pend_reg;
    logic rx_pend_next;
    logic [2:0] mem_late;

    // Expand byte strobes over the low flag bits
    function automatic logic [8:0] strobe_mask(input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return m[8:0];
    endfunction

    assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wmask = strobe_mask(wstrb_reg);

    // Write path: address and data are caught in either order
    always_comb begin
        aw_full_next = aw_full_reg;
        awaddr_next = awaddr_reg;
        w_full_next = w_full_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        en_next = en_reg;
        clr_vec = '0;
        if (s_axi_awvalid && awready_reg) begin
            aw_full_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_full_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = err_flags_pkg::RESP_OKAY;
            case (awaddr_reg[11:2])
                err_flags_pkg::OFF_FLAGS[11:2]: begin
                    // Flags are read-only; the write is accepted and dropped
                    clr_vec = '0; // RULE_09
                end
                err_flags_pkg::OFF_CLEAR[11:2]: begin
                    clr_vec = wdata_reg[8:0] & wmask; // RULE_10
                end
                err_flags_pkg::OFF_ENABLE[11:2]: begin
                    en_next = (en_reg & ~wmask) | (wdata_reg[8:0] & wmask);
                end
                default: begin
                    bresp_next = err_flags_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // Readies drop while a response waits, one write at a time
        awready_next = !aw_full_next && !bvalid_next;
        wready_next = !w_full_next && !bvalid_next;
    end

    // Register the write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            w_full_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= err_flags_pkg::RESP_OKAY;
            en_reg <= err_flags_pkg::ENABLE_RESET;
        end else begin
            aw_full_reg <= aw_full_next;
            awaddr_reg <= awaddr_next;
            w_full_reg <= w_full_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            en_reg <= en_next;
        end
    end

    // Read path: data is captured at the address handshake
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = err_flags_pkg::RESP_OKAY;
            case (s_axi_araddr[11:2])
                err_flags_pkg::OFF_FLAGS[11:2]: begin
                    rdata_next = {23'h000000, flags_reg}; // RULE_09
                end
                err_flags_pkg::OFF_CLEAR[11:2]: begin
                    rdata_next = 32'h0000_0000;
                end
                err_flags_pkg::OFF_ENABLE[11:2]: begin
                    rdata_next = {23'h000000, en_reg};
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = err_flags_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        arready_next = !rvalid_next;
    end

    // Register the read path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= err_flags_pkg::RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
        end
    end

    // One deadline watchdog per exchange-memory requestor
    genvar gi;
    generate
        for (gi = 0; gi < err_flags_pkg::MEM_PORTS; gi++) begin : g_mem
            mem_deadline_watch u_watch (
                .aclk(aclk),
                .aresetn(aresetn),
                .port(mem_port[gi]),
                .late(mem_late[gi]) // RULE_04 RULE_05 RULE_06
            );
        end
    endgenerate

    // Error detectors; each raises one set pulse for the flag bank
    always_comb begin
        set_vec = '0;
        prev_valid_next = prev_valid_reg;
        prev_off_next = prev_off_reg;
        set_vec[err_flags_pkg::BIT_WHITELIST] =
            wl_result_needed && wl_search_busy; // RULE_01
        // Both units see the same overlap of events
        set_vec[err_flags_pkg::BIT_CTRL_PF] = prefetch_instant &&
            evt_next_programmed && evt_active; // RULE_02
        set_vec[err_flags_pkg::BIT_SCHED_PF] = prefetch_instant &&
            evt_next_programmed && evt_active; // RULE_02
        if (et_entry_valid) begin
            set_vec[err_flags_pkg::BIT_ENTRY] = prev_valid_reg &&
                (prev_off_reg != et_entry_has_offset); // RULE_03
            prev_valid_next = 1'b1;
            prev_off_next = et_entry_has_offset;
        end
        set_vec[err_flags_pkg::BIT_SCHED_MEM] =
            mem_late[err_flags_pkg::MEM_SCHED]; // RULE_04
        set_vec[err_flags_pkg::BIT_RADIO_MEM] =
            mem_late[err_flags_pkg::MEM_RADIO]; // RULE_05
        set_vec[err_flags_pkg::BIT_PKT_MEM] =
            mem_late[err_flags_pkg::MEM_PKT]; // RULE_06
        // Done in the same cycle counts as in time for the new block
        set_vec[err_flags_pkg::BIT_RX_DEC] = rx_block_in &&
            rx_pend_reg && !rx_decrypt_done; // RULE_07
        rx_pend_next = rx_block_in || (rx_pend_reg && !rx_decrypt_done);
        set_vec[err_flags_pkg::BIT_TX_ENC] =
            tx_send_req && !tx_block_ready; // RULE_08
    end

    // Sticky flags: a set in the clearing cycle wins over the clear
    always_comb begin
        flags_next = (flags_reg & ~clr_vec) | set_vec; // RULE_10
        // Interrupt follows the flags it will be compared with
        irq_next = |(flags_next & en_next);
    end

    // Register flags, interrupt and detector history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_reg <= err_flags_pkg::FLAGS_RESET; // RULE_09
            irq_reg <= 1'b0;
            prev_valid_reg <= 1'b0;
            prev_off_reg <= 1'b0;
            rx_pend_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            irq_reg <= irq_next;
            prev_valid_reg <= prev_valid_next;
            prev_off_reg <= prev_off_next;
            rx_pend_reg <= rx_pend_next;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign err_flags = flags_reg;
    assign irq = irq_reg;

    // Checks on flag setting and retention
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_whitelist_set: assert property ( // RULE_01
        wl_result_needed && wl_search_busy |=> err_flags[8])
        else $error("whitelist late flag not set");

    chk_prefetch_pair: assert property ( // RULE_02
        prefetch_instant && evt_active && evt_next_programmed
        |=> err_flags[7] && err_flags[6])
        else $error("prefetch flags not both set");

    // Entries two cycles apart with one idle cycle between, as the table reader issues them
    chk_entry_mismatch: assert property ( // RULE_03
        et_entry_valid ##1 !et_entry_valid ##1 (et_entry_valid &&
        (et_entry_has_offset != $past(et_entry_has_offset, 2)))
        |=> err_flags[5])
        else $error("entry timing flag not set");

    chk_sched_mem_late: assert property ( // RULE_04
        (mem_port[2].req && !mem_port[2].gnt) [*8] |=> ##[0:1] err_flags[4])
        else $error("scheduler memory flag late");

    chk_radio_mem_late: assert property ( // RULE_05
        (mem_port[1].req && !mem_port[1].gnt) [*8] |=> ##[0:1] err_flags[3])
        else $error("radio memory flag late");

    chk_pkt_mem_late: assert property ( // RULE_06
        $rose(err_flags[2]) |-> $past(mem_port[0].req, 2) &&
        !$past(mem_port[0].gnt, 2))
        else $error("packet memory flag without waiting request");

    chk_rx_overrun: assert property ( // RULE_07
        rx_block_in ##1 !rx_decrypt_done ##1 (rx_block_in &&
        !rx_decrypt_done) |=> err_flags[1])
        else $error("decrypt late flag not set");

    chk_tx_not_ready: assert property ( // RULE_08
        tx_send_req && !tx_block_ready |=> err_flags[0])
        else $error("encrypt late flag not set");

    chk_flags_reset: assert property ( // RULE_09
        !$past(aresetn) |-> err_flags == 9'h000 && !irq)
        else $error("flags not clear after reset");

    chk_flag_sticky: assert property ( // RULE_10
        1'b1 |=> (err_flags & $past(err_flags & ~clr_vec)) ==
        $past(err_flags & ~clr_vec))
        else $error("flag dropped without clear");

    chk_irq_level: assert property (
        irq == |(err_flags & en_reg))
        else $error("interrupt disagrees with enabled flags");

endmodule

// File: link_err_flags_test.sv
// Self-checking bench for the link-layer error flag bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((e) !== (g)) begin \
        n_mismatch++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
end
module link_err_flags_test;
    // Pulse lanes of the event inputs
    localparam logic [5:0] P_WL = 6'h01;
    localparam logic [5:0] P_PF = 6'h02;
    localparam logic [5:0] P_ET = 6'h04;
    localparam logic [5:0] P_RXI = 6'h08;
    localparam logic [5:0] P_RXD = 6'h10;
    localparam logic [5:0] P_TX = 6'h20;
    logic aclk, aresetn;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic wl_search_busy, evt_active, evt_next_programmed;
    logic et_entry_has_offset, tx_block_ready, irq;
    logic [5:0] pls;
    err_flags_pkg::mem_port_t [2:0] mem_port;
    logic [8:0] err_flags, exp_flags, en, m;
    int n_mismatch, n_checks, seed, k, j;

    link_err_flags uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wl_search_busy(wl_search_busy),
        .wl_result_needed(pls[0]), .evt_active(evt_active),
        .evt_next_programmed(evt_next_programmed),
        .prefetch_instant(pls[1]), .et_entry_valid(pls[2]),
        .et_entry_has_offset(et_entry_has_offset), .mem_port(mem_port),
        .rx_block_in(pls[3]), .rx_decrypt_done(pls[4]),
        .tx_send_req(pls[5]), .tx_block_ready(tx_block_ready),
        .err_flags(err_flags), .irq(irq));

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Flag bits one cause sets; both prefetch flags share a cause
    function automatic logic [8:0] cause_bits(input int c);
        return (c == 6 || c == 7) ? 9'h0c0 : 9'(1 << c);
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic timeout();
        n_mismatch++;
        $display("MISMATCH bus_answer exp 1 got 0");
        report_and_stop();
    endtask

    // Design outputs read right after the edge still hold pre-edge values
    task automatic bus_wr(input logic [11:0] a, input logic [31:0] v,
                          input logic [3:0] s, output logic [1:0] resp);
        int i;
        resp = 2'h3;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        if (i == 50) timeout();
    endtask

    task automatic bus_rd(input logic [11:0] a, output logic [31:0] v,
                          output logic [1:0] resp);
        int i;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                v = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (i == 50) timeout();
    endtask

    task automatic pulse(input logic [5:0] p);
        @(posedge aclk);
        pls <= p;
        @(posedge aclk);
        pls <= 6'h00;
    endtask

    // Compare pins and the register read against the model
    task automatic check_all();
        logic [31:0] v;
        logic [1:0] rs;
        repeat (2) @(posedge aclk);
        #1;
        `CHK("err_flags", exp_flags, err_flags)
        `CHK("irq", |(exp_flags & en), irq)
        bus_rd(err_flags_pkg::OFF_FLAGS, v, rs);
        `CHK("flags_read", {23'h0, exp_flags}, v)
        `CHK("flags_resp", err_flags_pkg::RESP_OKAY, rs)
    endtask

    task automatic set_en(input logic [8:0] v);
        bus_wr(err_flags_pkg::OFF_ENABLE, {23'h0, v}, 4'hf, r);
        en = v;
        `CHK("enable_resp", err_flags_pkg::RESP_OKAY, r)
    endtask

    // Each cause in its failing form
    task automatic trig(input int c);
        case (c)
            8: begin
                wl_search_busy <= 1'b1;
                pulse(P_WL);
                wl_search_busy <= 1'b0;
            end
            6, 7: begin
                evt_active <= 1'b1;
                evt_next_programmed <= 1'b1;
                pulse(P_PF);
                evt_active <= 1'b0;
                evt_next_programmed <= 1'b0;
            end
            5: begin
                et_entry_has_offset <= 1'b1;
                pulse(P_ET);
                et_entry_has_offset <= 1'b0;
                pulse(P_ET);
            end
            2, 3, 4: begin
                mem_port[c-2].req <= 1'b1;
                repeat (10) @(posedge aclk);
                mem_port[c-2].req <= 1'b0;
            end
            1: begin
                pulse(P_RXI);
                pulse(P_RXI);
                pulse(P_RXD);
            end
            default: pulse(P_TX);
        endcase
        repeat (3) @(posedge aclk);
    endtask

    // Each cause served in time: no flag may rise
    task automatic in_time(input int c);
        case (c)
            8: pulse(P_WL);
            6, 7: begin
                evt_next_programmed <= 1'b1;
                pulse(P_PF);
                evt_next_programmed <= 1'b0;
            end
            5: begin
                pulse(P_ET);
                pulse(P_ET);
            end
            2, 3, 4: begin
                mem_port[c-2].req <= 1'b1;
                repeat (6) @(posedge aclk);
                mem_port[c-2].gnt <= 1'b1;
                @(posedge aclk);
                mem_port[c-2] <= '0;
            end
            1: begin
                pulse(P_RXI);
                pulse(P_RXD);
                pulse(P_RXI);
                pulse(P_RXD);
            end
            default: begin
                tx_block_ready <= 1'b1;
                pulse(P_TX);
                tx_block_ready <= 1'b0;
            end
        endcase
        repeat (3) @(posedge aclk);
    endtask

    initial begin
        seed = 79;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, wl_search_busy, evt_active} = '0;
        {evt_next_programmed, et_entry_has_offset, tx_block_ready} = '0;
        pls = 6'h00;
        mem_port = '0;
        n_mismatch = 0;
        n_checks = 0;
        exp_flags = err_flags_pkg::FLAGS_RESET;
        en = err_flags_pkg::ENABLE_RESET;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        bus_rd(err_flags_pkg::OFF_ENABLE, d, r);
        `CHK("enable_reset", 32'h0, d)
        bus_rd(err_flags_pkg::OFF_CLEAR, d, r);
        `CHK("clear_reads_zero", 32'h0, d)
        bus_rd(12'h00c, d, r);
        `CHK("unmapped_rd", {err_flags_pkg::RESP_SLVERR, 32'h0}, {r, d})
        bus_wr(12'h00c, 32'hffffffff, 4'hf, r);
        `CHK("unmapped_wr", err_flags_pkg::RESP_SLVERR, r)
        // Byte lanes: lane 0 then lane 1 of the enable word
        bus_wr(err_flags_pkg::OFF_ENABLE, 32'h1ff, 4'h1, r);
        bus_wr(err_flags_pkg::OFF_ENABLE, 32'h100, 4'h2, r);
        en = 9'h1ff;
        bus_rd(err_flags_pkg::OFF_ENABLE, d, r);
        `CHK("enable_lanes", 32'h1ff, d)
        for (k = 0; k < 9; k++) begin
            in_time(k);
            check_all();
        end
        // Every cause sets its flag; writes to the flag register cannot touch it
        for (k = 0; k < 9; k++) begin
            trig(k);
            exp_flags |= cause_bits(k);
            check_all();
            bus_wr(err_flags_pkg::OFF_FLAGS, 32'h0, 4'hf, r);
            check_all();
        end
        // Masked interrupt with flags held over a long idle stretch
        set_en(9'h000);
        repeat (40) @(posedge aclk);
        check_all();
        bus_wr(err_flags_pkg::OFF_CLEAR, 32'h1ff, 4'hf, r);
        exp_flags = 9'h000;
        check_all();
        // Random causes, masks and clears
        for (j = 0; j < 40; j++) begin
            k = $unsigned($random(seed)) % 9;
            if ($random(seed) & 1) set_en(9'($random(seed)));
            trig(k);
            exp_flags |= cause_bits(k);
            check_all();
            m = 9'($random(seed));
            bus_wr(err_flags_pkg::OFF_CLEAR, {23'h0, m}, 4'hf, r);
            exp_flags &= ~m;
            check_all();
        end
        // Reset in mid-run drops a set flag and the enables
        trig(0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        exp_flags = err_flags_pkg::FLAGS_RESET;
        en = err_flags_pkg::ENABLE_RESET;
        check_all();
        report_and_stop();
    end
endmodule
